//--- rtl/swo_pkg.sv
// Package of constants and types for the supply watchdog outputs block
package swo_pkg;
  // Clock rate of clk_sys
  localparam longint unsigned CLK_HZ         = 64'd250_000_000;
  // Watchdog timeout, nominal, in milliseconds
  localparam longint unsigned WD_TIMEOUT_MS  = 64'd1600;
  // Least reset timeout, in milliseconds
  localparam longint unsigned RST_TIMEOUT_MS = 64'd140;
  // Startup window after reset, in seconds
  localparam longint unsigned STARTUP_S      = 64'd54;
  // Derived cycle counts: the watchdog limit rounds down, the least reset time rounds up
  localparam longint unsigned WD_CYCLES      = (WD_TIMEOUT_MS * CLK_HZ) / 64'd1000;
  localparam longint unsigned RST_CYCLES     =
    (RST_TIMEOUT_MS * CLK_HZ + 64'd999) / 64'd1000;
  localparam longint unsigned STARTUP_CYCLES = STARTUP_S * CLK_HZ;
  // Width of every timebase counter
  localparam int unsigned     CNT_W          = 44;
  // Number of synchroniser stages for pin inputs
  localparam int unsigned     SYNC_STAGES    = 3;
  // Reset values
  localparam logic            FAULT_N_RST    = 1'b1;
  localparam logic            SYSRST_N_RST   = 1'b0;

  // Watchdog timer states, one-hot
  typedef enum logic [3:0] {
    SWO_WD_OFF     = 4'h1,
    SWO_WD_HOLD    = 4'h2,
    SWO_WD_STARTUP = 4'h4,
    SWO_WD_RUN     = 4'h8
  } swo_wd_state_t;
endpackage

//--- rtl/swo_sync_if.sv
// Interface carrying synchronised pin levels into the watchdog core
`timescale 1ns/100ps
`default_nettype none
interface swo_sync_if;
  logic kick;
  logic kick_edge;
  logic manual_reset_n;
  logic margin_n;
  logic kick_float;
  modport src (output kick, output kick_edge, output manual_reset_n, output margin_n,
               output kick_float);
  modport dst (input kick, input kick_edge, input manual_reset_n, input margin_n,
               input kick_float);
endinterface
`default_nettype wire

//--- rtl/swo_input_sync.sv
// Three-stage synchronisers and kick edge detection for the pin inputs
`timescale 1ns/100ps
`default_nettype none
module swo_input_sync
  import swo_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic kick_input,
  input  wire logic kick_floating,
  input  wire logic manual_reset_n,
  input  wire logic margin_n,
  swo_sync_if.src   sync
);
  localparam int unsigned NIN = 4;
  logic [NIN-1:0] pins;
  logic [NIN-1:0] st1_reg, st2_reg, st3_reg, st1_next, st2_next, st3_next;
  logic [NIN-1:0] lvl_reg, lvl_next;
  logic           edge_reg, edge_next;

  assign pins = {kick_floating, margin_n, manual_reset_n, kick_input};

  // A level counts once stages two and three agree; stage one feeds stage two only
  always_comb begin
    st1_next  = pins;
    st2_next  = st1_reg;
    st3_next  = st2_reg;
    lvl_next  = lvl_reg;
    edge_next = 1'b0;
    for (int i = 0; i < NIN; i++) begin
      if (st2_reg[i] == st3_reg[i]) begin
        lvl_next[i] = st3_reg[i];
      end
    end
    // Both edge directions of the settled kick level count RL15
    edge_next = (lvl_next[0] != lvl_reg[0]);
  end

  // Inactive pin levels at reset so no false kick or manual reset appears
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st1_reg  <= 4'h6;
      st2_reg  <= 4'h6;
      st3_reg  <= 4'h6;
      lvl_reg  <= 4'h6;
      edge_reg <= 1'b0;
    end else begin
      st1_reg  <= st1_next;
      st2_reg  <= st2_next;
      st3_reg  <= st3_next;
      lvl_reg  <= lvl_next;
      edge_reg <= edge_next;
    end
  end

  assign sync.kick           = lvl_reg[0];
  assign sync.manual_reset_n = lvl_reg[1];
  assign sync.margin_n       = lvl_reg[2];
  assign sync.kick_float     = lvl_reg[3];
  assign sync.kick_edge      = edge_reg; // RL15
endmodule
`default_nettype wire

//--- rtl/swo_watchdog.sv
// Supply watchdog core: fault output, system reset and watchdog timer
// How it works
// RL1: Fault output held low while any rail is undervoltage.
// RL2: Fault output releases at once when all rails recover.
// RL3: Fault-output variant: with rails good, watchdog expiry drives fault output low.
// RL4: Kick edge or manual reset low releases the fault output.
// RL5: After manual reset rises, timer idles for reset timeout first.
// RL6: Margin override low forces the fault output high.
// RL7: Reset variant: stuck kick past timeout asserts system reset, clears timer.
// RL8: Timer clears on system reset in the reset variant, on manual reset in the other, and on every kick edge.
// RL9: Reset variant: 54 s startup window for the first kick.
// RL10: Floating kick input disables the watchdog completely.
// RL11: Host kicks faster than the timeout or leaves the input open.
// RL12: System reset held while faults persist, then for reset timeout.
// RL13: Internal reset timeout is at least 140 ms.
// RL14: All timeouts come from clk_sys counters with parameter limits.
// RL15: Pin inputs are synchronised; kick edges found after synchronising.
`timescale 1ns/100ps
`default_nettype none
module swo_watchdog
  import swo_pkg::*;
#(
  parameter int unsigned          N_RAILS      = 4,
  parameter bit                   RESET_VARIANT = 1'b0,
  parameter longint unsigned      WD_LIMIT     = WD_CYCLES,
  parameter longint unsigned      RST_LIMIT    = RST_CYCLES,
  parameter longint unsigned      START_LIMIT  = STARTUP_CYCLES
)(
  input  wire logic               clk_sys,
  input  wire logic               reset_n,
  input  wire logic [N_RAILS-1:0] rail_under_flag,
  input  wire logic               kick_input,
  input  wire logic               kick_floating,
  input  wire logic               manual_reset_n,
  input  wire logic               margin_n,
  output logic                    watchdog_fault_n,
  output logic                    system_reset_n
);
  import swo_pkg::*;

  // Refuse limits the counters cannot hold, at elaboration
  if (N_RAILS < 1 || WD_LIMIT < 1 || RST_LIMIT < 1 || START_LIMIT < 1 ||
      WD_LIMIT >= (64'd1 << CNT_W) || RST_LIMIT >= (64'd1 << CNT_W) ||
      START_LIMIT >= (64'd1 << CNT_W)) begin : g_param_check
    $error("swo_watchdog: parameter out of range");
  end

  localparam logic [CNT_W-1:0] WD_LIM  = CNT_W'(WD_LIMIT);
  localparam logic [CNT_W-1:0] RST_LIM = CNT_W'(RST_LIMIT);
  localparam logic [CNT_W-1:0] ST_LIM  = CNT_W'(START_LIMIT);

  swo_sync_if sync ();

  swo_input_sync u_sync (
    .clk_sys        (clk_sys),
    .reset_n        (reset_n),
    .kick_input     (kick_input),
    .kick_floating  (kick_floating),
    .manual_reset_n (manual_reset_n),
    .margin_n       (margin_n),
    .sync           (sync)
  );

  logic any_under;
  assign any_under = |rail_under_flag;

  // Rail flags come from comparators inside the supervisor, already on clk_sys
  // System reset: asserted on fault, stretched by the reset timeout
  logic [CNT_W-1:0] rst_cnt_reg, rst_cnt_next;
  logic             sysrst_n_reg, sysrst_n_next;
  logic             wd_bite;
  logic             rst_cause;

  always_comb begin
    rst_cause     = any_under || !sync.manual_reset_n ||
                    (RESET_VARIANT && wd_bite); // RL12 RL7
    rst_cnt_next  = rst_cnt_reg;
    sysrst_n_next = sysrst_n_reg;
    if (rst_cause) begin
      rst_cnt_next  = '0;
      sysrst_n_next = 1'b0; // RL12
    end else if (!sysrst_n_reg) begin
      // The release comes only after RST_LIM clean cycles RL13 RL14
      if (rst_cnt_reg >= RST_LIM - 1'b1) begin
        sysrst_n_next = 1'b1;
      end else begin
        rst_cnt_next = rst_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rst_cnt_reg  <= '0;
      sysrst_n_reg <= SYSRST_N_RST;
    end else begin
      rst_cnt_reg  <= rst_cnt_next;
      sysrst_n_reg <= sysrst_n_next;
    end
  end

  // Manual reset hold for the fault-output variant: timer idles after release
  logic [CNT_W-1:0] mr_cnt_reg, mr_cnt_next;
  logic             mr_hold_reg, mr_hold_next;

  always_comb begin
    mr_cnt_next  = mr_cnt_reg;
    mr_hold_next = mr_hold_reg;
    if (!sync.manual_reset_n) begin
      mr_cnt_next  = '0;
      mr_hold_next = 1'b1;
    end else if (mr_hold_reg) begin
      if (mr_cnt_reg >= RST_LIM - 1'b1) begin
        mr_hold_next = 1'b0; // RL5
      end else begin
        mr_cnt_next = mr_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      mr_cnt_reg  <= '0;
      mr_hold_reg <= 1'b0;
    end else begin
      mr_cnt_reg  <= mr_cnt_next;
      mr_hold_reg <= mr_hold_next;
    end
  end

  // Watchdog timer state machine
  swo_wd_state_t    st_reg, st_next;
  logic [CNT_W-1:0] wd_cnt_reg, wd_cnt_next;
  logic             idle_cond;

  // Reset variant idles while system reset is low; other variant while MR holds
  assign idle_cond = RESET_VARIANT ? !sysrst_n_reg
                                   : (!sync.manual_reset_n || mr_hold_reg);

  always_comb begin
    st_next     = st_reg;
    wd_cnt_next = wd_cnt_reg;
    wd_bite     = 1'b0;
    unique case (st_reg)
      SWO_WD_OFF: begin
        wd_cnt_next = '0;
        if (!sync.kick_float) begin
          st_next = SWO_WD_HOLD;
        end
      end
      SWO_WD_HOLD: begin
        wd_cnt_next = '0; // RL8
        if (!idle_cond) begin
          st_next = RESET_VARIANT ? SWO_WD_STARTUP : SWO_WD_RUN; // RL9 RL5
        end
      end
      SWO_WD_STARTUP: begin
        if (sync.kick_edge) begin
          wd_cnt_next = '0; // RL8
          st_next     = SWO_WD_RUN;
        end else if (wd_cnt_reg >= ST_LIM - 1'b1) begin
          wd_bite     = 1'b1; // RL9
          wd_cnt_next = '0;
          st_next     = SWO_WD_HOLD;
        end else begin
          wd_cnt_next = wd_cnt_reg + 1'b1;
        end
      end
      SWO_WD_RUN: begin
        if (sync.kick_edge) begin
          wd_cnt_next = '0; // RL8
        end else if (wd_cnt_reg >= WD_LIM - 1'b1) begin
          wd_bite     = 1'b1; // RL3 RL7
          wd_cnt_next = '0; // RL7
          if (RESET_VARIANT) begin
            st_next = SWO_WD_HOLD;
          end
        end else begin
          wd_cnt_next = wd_cnt_reg + 1'b1;
        end
      end
    endcase
    // Floating input overrides every state; idle conditions override every state but SWO_WD_OFF
    if (sync.kick_float) begin
      st_next     = SWO_WD_OFF; // RL10
      wd_cnt_next = '0;
      wd_bite     = 1'b0; // RL10
    end else if (idle_cond && st_reg != SWO_WD_OFF) begin
      st_next     = SWO_WD_HOLD; // RL8 RL5
      wd_cnt_next = '0;
      wd_bite     = 1'b0; // An idle timer never bites, even on its last count RL4
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_reg     <= SWO_WD_OFF;
      wd_cnt_reg <= '0;
    end else begin
      st_reg     <= st_next;
      wd_cnt_reg <= wd_cnt_next;
    end
  end

  // Fault output: expiry latches low until a kick edge, manual reset or floating kick input
  logic fault_n_reg, fault_n_next;
  logic bite_lat_reg, bite_lat_next;

  always_comb begin
    bite_lat_next = bite_lat_reg;
    if (sync.kick_edge || !sync.manual_reset_n || sync.kick_float) begin
      bite_lat_next = 1'b0; // RL4
    end
    if (!RESET_VARIANT && wd_bite) begin
      bite_lat_next = 1'b1; // RL3
    end
    // Margin wins, then rails, then the watchdog latch; recovery has no delay
    if (!sync.margin_n) begin
      fault_n_next = 1'b1; // RL6
    end else if (any_under) begin
      fault_n_next = 1'b0; // RL1
    end else begin
      fault_n_next = RESET_VARIANT ? 1'b1 : !bite_lat_next; // RL2 RL3
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      fault_n_reg  <= FAULT_N_RST;
      bite_lat_reg <= 1'b0;
    end else begin
      fault_n_reg  <= fault_n_next;
      bite_lat_reg <= bite_lat_next;
    end
  end

  assign watchdog_fault_n = fault_n_reg;
  assign system_reset_n   = sysrst_n_reg;

  // Checks
  sequence rail_low_s;
    any_under && sync.margin_n;
  endsequence

  rail_fault_low_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL1
    rail_low_s |=> !watchdog_fault_n)
    else $error("fault output not low under undervoltage");

  rail_release_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL2
    (!any_under && sync.margin_n && !bite_lat_next && !wd_bite) |=> watchdog_fault_n)
    else $error("fault output not released on rail recovery");

  margin_force_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL6
    !sync.margin_n |=> watchdog_fault_n)
    else $error("margin override did not force fault output high");

  kick_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL8
    (sync.kick_edge && st_reg == SWO_WD_RUN && !sync.kick_float && !idle_cond)
      |=> wd_cnt_reg == '0)
    else $error("kick edge did not clear the timer");

  float_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL10
    sync.kick_float |-> !wd_bite ##1 st_reg == SWO_WD_OFF)
    else $error("floating kick input did not disable timer");

  bite_fault_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL3
    (!RESET_VARIANT && wd_bite && sync.margin_n) |=> !watchdog_fault_n)
    else $error("expiry did not drive fault output low");

  mr_release_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL4
    (!sync.manual_reset_n && !any_under) |=> watchdog_fault_n)
    else $error("manual reset did not release fault output");

  mr_idle_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL5
    ($rose(sync.manual_reset_n) && !RESET_VARIANT) |-> mr_hold_reg ##1 wd_cnt_reg == '0)
    else $error("timer counted during manual reset hold");

  sysrst_assert_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL12
    rst_cause |=> !system_reset_n)
    else $error("system reset not asserted on fault");

  sysrst_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL13
    $rose(system_reset_n) |-> rst_cnt_reg == RST_LIM - 1'b1)
    else $error("system reset released before timeout");

  bite_reset_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL7
    (RESET_VARIANT && wd_bite) |=> !system_reset_n && wd_cnt_reg == '0)
    else $error("stuck kick did not assert system reset");

  // Release paths of the bite latch, and the timer kept at zero while held
  kick_release_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL4
    (!RESET_VARIANT && sync.kick_edge && !wd_bite && !any_under && sync.margin_n)
      |=> watchdog_fault_n)
    else $error("kick edge did not release fault output");

  hold_idle_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL5
    (!RESET_VARIANT && mr_hold_reg) |=> wd_cnt_reg == '0)
    else $error("timer counted during manual reset hold");

  float_release_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL10
    (sync.kick_float && !any_under && sync.margin_n) |=> watchdog_fault_n)
    else $error("floating kick input did not release fault output");
endmodule
`default_nettype wire

//--- testbench/swo_host_model.sv
// Host model that toggles the kick pin or leaves it floating
`timescale 1ns/100ps
`default_nettype none
module swo_host_model (
  input  wire logic       clk_sys,
  input  wire logic       run,
  input  wire logic       float_req,
  input  wire logic [7:0] period,
  output var logic        kick_input,
  output var logic        kick_floating
);
  int cnt;

  initial begin
    kick_input = 1'b0;
    kick_floating = 1'b0;
    cnt = 0;
  end

  // Pin changes land on the falling edge, clear of the sampling edge
  always @(negedge clk_sys) begin
    if (float_req) begin
      // An open pin holds no level, so the line wanders every cycle
      kick_floating <= 1'b1;
      kick_input    <= ~kick_input;
      cnt           <= 0;
    end else begin
      kick_floating <= 1'b0;
      // A late start kicks at once, since the count kept running
      if (run && cnt >= int'(period)) begin
        kick_input <= ~kick_input;
        cnt        <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/test_supply_watchdog_outputs.sv
// Self-checking bench for the supply watchdog block
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("unexpected at %0t got %h expected %h", $time, got, exp); end end
module test_supply_watchdog_outputs;
  import swo_pkg::*;
  // Short limits keep the run brief; every expectation derives from them
  localparam int WDL = 50;
  localparam int RSL = 20;
  localparam int STL = 100;
  logic        clk_sys;
  logic        reset_n;
  logic [3:0]  rail_under_flag;
  logic        manual_reset_n;
  logic        margin_n;
  logic        run;
  logic        float_req;
  logic [7:0]  period;
  wire logic   kick_input;
  wire logic   kick_floating;
  wire logic   watchdog_fault_n;
  wire logic   system_reset_n;
  wire logic   watchdog_fault_n_rv;
  wire logic   system_reset_n_rv;
  int          n_mismatch;
  int          checked;
  int          n;
  logic [31:0] seed;
  bit          bitten;

  swo_watchdog #(.N_RAILS(4), .RESET_VARIANT(1'b0), .WD_LIMIT(WDL), .RST_LIMIT(RSL),
    .START_LIMIT(STL)) swo_watchdog_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .rail_under_flag(rail_under_flag),
    .kick_input(kick_input), .kick_floating(kick_floating),
    .manual_reset_n(manual_reset_n), .margin_n(margin_n),
    .watchdog_fault_n(watchdog_fault_n), .system_reset_n(system_reset_n));

  // Reset variant on the same pins; its startup window and resets are checked last
  swo_watchdog #(.N_RAILS(4), .RESET_VARIANT(1'b1), .WD_LIMIT(WDL), .RST_LIMIT(RSL),
    .START_LIMIT(STL)) swo_watchdog_rv_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .rail_under_flag(rail_under_flag),
    .kick_input(kick_input), .kick_floating(kick_floating),
    .manual_reset_n(manual_reset_n), .margin_n(margin_n),
    .watchdog_fault_n(watchdog_fault_n_rv), .system_reset_n(system_reset_n_rv));

  swo_host_model swo_host_model_inst (
    .clk_sys(clk_sys), .run(run), .float_req(float_req), .period(period),
    .kick_input(kick_input), .kick_floating(kick_floating));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Expected fault level: margin wins, then rails, then the bite latch
  function automatic logic exp_fault(input bit under, input bit mg, input bit bt);
    if (!mg) return 1'b1;
    if (under) return 1'b0;
    return !bt;
  endfunction

  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Bounded wait for an output level; sel 0 fault, 1 system reset, 2 reset-variant reset
  task automatic wait_out(input int sel, input logic lvl, input int bound, output int cyc);
    logic cur;
    cyc = 0;
    checked++;
    cur = (sel == 2) ? system_reset_n_rv : (sel == 1) ? system_reset_n : watchdog_fault_n;
    while (cur !== lvl) begin
      @(negedge clk_sys);
      cyc++;
      cur = (sel == 2) ? system_reset_n_rv : (sel == 1) ? system_reset_n : watchdog_fault_n;
      if (cyc > bound) begin
        n_mismatch++;
        $display("unexpected at %0t got %h expected %h", $time, cur, lvl);
        end_sim();
      end
    end
  endtask

  // Compare the fault output with the model on every cycle
  task automatic hold_fault(input int k);
    repeat (k) begin
      @(negedge clk_sys);
      `CHK(watchdog_fault_n, exp_fault(rail_under_flag != 4'h0, margin_n, bitten))
      `CHK(watchdog_fault_n_rv, exp_fault(rail_under_flag != 4'h0, margin_n, 1'b0))
    end
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial begin
    reset_n = 1'b0;
    rail_under_flag = 4'h0;
    manual_reset_n = 1'b1;
    margin_n = 1'b1;
    run = 1'b0;
    float_req = 1'b0;
    period = 8'h0a;
    n_mismatch = 0;
    checked = 0;
    seed = 32'h92dbc842;
    bitten = 1'b0;
    repeat (12) @(negedge clk_sys);
    `CHK(watchdog_fault_n, 1'b1)
    `CHK(system_reset_n, 1'b0)
    reset_n = 1'b1;
    run = 1'b1;
    seed = xs(seed);
    period = 8'h04 + {4'h0, seed[3:0]};
    wait_out(1'b1, 1'b1, RSL + 10, n);
    `CHK(n >= RSL - 2, 1'b1)
    // Kicks at a random spacing keep the timer from biting
    hold_fault(6 * WDL);
    // Kicks stop: the bite comes near the timeout and latches
    run = 1'b0;
    wait_out(1'b0, 1'b0, 2 * WDL, n);
    `CHK(n >= WDL - 20, 1'b1)
    bitten = 1'b1;
    hold_fault(2 * WDL);
    run = 1'b1;
    wait_out(1'b0, 1'b1, 10, n);
    bitten = 1'b0;
    // Random undervoltage pulls the fault output low on the next edge
    seed = xs(seed);
    rail_under_flag = seed[3:0] | 4'h1;
    @(negedge clk_sys);
    `CHK(watchdog_fault_n, 1'b0)
    hold_fault(WDL);
    `CHK(system_reset_n, 1'b0)
    // Margin override wins over a bad rail
    margin_n = 1'b0;
    wait_out(1'b0, 1'b1, 10, n);
    hold_fault(20);
    margin_n = 1'b1;
    wait_out(1'b0, 1'b0, 10, n);
    // Fault releases at once; system reset waits out its timeout
    rail_under_flag = 4'h0;
    @(negedge clk_sys);
    `CHK(watchdog_fault_n, 1'b1)
    `CHK(system_reset_n, 1'b0)
    wait_out(1'b1, 1'b1, RSL + 10, n);
    `CHK(n >= RSL - 2, 1'b1)
    // Bite, then manual reset releases it and delays the next count
    run = 1'b0;
    wait_out(1'b0, 1'b0, 2 * WDL, n);
    manual_reset_n = 1'b0;
    wait_out(1'b0, 1'b1, 10, n);
    wait_out(1'b1, 1'b0, 10, n);
    repeat (5) @(negedge clk_sys);
    manual_reset_n = 1'b1;
    wait_out(1'b0, 1'b0, RSL + 2 * WDL, n);
    `CHK(n >= RSL + WDL - 8, 1'b1)
    // Open kick pin clears the latch and disables the timer
    float_req = 1'b1;
    wait_out(1'b0, 1'b1, 10, n);
    hold_fault(3 * WDL);
    // Reset variant: an unkicked startup window ends in a system reset
    float_req = 1'b0;
    wait_out(2, 1'b0, STL + 20, n);
    `CHK(n >= STL, 1'b1)
    wait_out(2, 1'b1, RSL + 10, n);
    `CHK(n >= RSL - 2, 1'b1)
    // Steady kicks keep it out of reset; a stuck kick bites after the timeout
    run = 1'b1;
    repeat (3 * WDL) begin
      @(negedge clk_sys);
      `CHK(system_reset_n_rv, 1'b1)
    end
    run = 1'b0;
    wait_out(2, 1'b0, 2 * WDL, n);
    `CHK(n >= WDL - 20, 1'b1)
    end_sim();
  end
endmodule
`default_nettype wire
